//--- pkg/fps_pkg.sv
package fps_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ          = 100;
	localparam int T_SUSP_LAT_US    = 30;
	localparam int T_PP_TYP_US      = 1500;
	localparam int T_PP_MAX_MS      = 3;
	localparam int T_ERASE_TYP_MS   = 16;
	localparam int T_ERASE_MAX_MS   = 30;
	localparam int T_CHIP_TYP_MS    = 520;
	localparam int T_CHIP_MAX_MS    = 800;
	localparam int SUSP_LAT_CYC     = T_SUSP_LAT_US * CLK_MHZ;
	localparam int PP_TYP_CYC       = T_PP_TYP_US * CLK_MHZ;
	localparam int PP_MAX_CYC       = T_PP_MAX_MS * 1000 * CLK_MHZ;
	localparam int ERASE_TYP_CYC    = T_ERASE_TYP_MS * 1000 * CLK_MHZ;
	localparam int ERASE_MAX_CYC    = T_ERASE_MAX_MS * 1000 * CLK_MHZ;
	localparam int CHIP_TYP_CYC     = T_CHIP_TYP_MS * 1000 * CLK_MHZ;
	localparam int CHIP_MAX_CYC     = T_CHIP_MAX_MS * 1000 * CLK_MHZ;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_ADDR    = 8'h04;
	localparam logic [7:0] OFF_WDATA   = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h14;
	localparam logic [7:0] OFF_ARRAY   = 8'h18;
	localparam int         ST_BUSY     = 0;
	localparam int         ST_WEL      = 1;
	localparam int         ST_BP_LSB   = 2;
	localparam int         ST_SRP_LSB  = 7;
	localparam int         ST_SUSP     = 9;
	localparam int         ST_DPD      = 10;
	localparam int         IRQ_DONE    = 0;
	localparam int         IRQ_REJ     = 1;
	localparam int         IRQ_SUSP    = 2;
	localparam logic [4:0] BP_RST      = 5'h00;
	localparam logic [1:0] SRP_RST     = 2'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [23:0] BP_BIG_UNIT   = 24'h040000;
	localparam logic [23:0] BP_SMALL_UNIT = 24'h001000;

	// ****************************************************************
	// Commands
	// ****************************************************************
	localparam logic [7:0] CMD_WRITE_ENABLE_COMMAND   = 8'h06;
	localparam logic [7:0] CMD_WRDI   = 8'h04;
	localparam logic [7:0] CMD_WRSR   = 8'h01;
	localparam logic [7:0] CMD_PP     = 8'h02;
	localparam logic [7:0] CMD_PE     = 8'h81;
	localparam logic [7:0] CMD_SE     = 8'h20;
	localparam logic [7:0] CMD_BE32   = 8'h52;
	localparam logic [7:0] CMD_BE64   = 8'hD8;
	localparam logic [7:0] CMD_CE     = 8'hC7;
	localparam logic [7:0] CMD_SUSP   = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_DP     = 8'hB9;
	localparam logic [7:0] CMD_RDP    = 8'hAB;

	typedef enum logic [2:0] {
		st_idle       = 3'h0,
		st_busy       = 3'h1,
		st_suspending = 3'h3,
		st_suspended  = 3'h2,
		st_dpd        = 3'h6
	} fps_state_t;

endpackage : fps_pkg

//--- pkg/fps_tmr_if.sv
interface fps_tmr_if;
	logic        load;
	logic        run;
	logic [31:0] value;
	logic        done;
	modport ctl (output load, output run, output value, input done);
	modport tmr (input load, input run, input value, output done);
endinterface : fps_tmr_if

//--- core/fps_timer.sv
module fps_timer (
	input wire logic pclk,    // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	fps_tmr_if.tmr   tif      // Load, run and done of one countdown.
);
	import fps_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
	} fps_tmr_state_t;

	fps_tmr_state_t r_ff;
	fps_tmr_state_t nxt_r;

	// The count pauses while run is low, so a suspended operation keeps its remaining time.
	always_comb begin
		nxt_r = r_ff;
		if (tif.load) begin
			nxt_r.cnt = tif.value;
		end else if (tif.run && r_ff.cnt != 32'h00000000) begin
			nxt_r.cnt = r_ff.cnt - 32'h00000001;
		end
	end

	assign tif.done = tif.run && !tif.load && (r_ff.cnt == 32'h00000001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

endmodule : fps_timer

//--- core/fps_flash_seq.sv
// Implementation choices: the placing of the registers and the APB register port.
module fps_flash_seq #(
	parameter int unsigned PP_CYC    = fps_pkg::PP_TYP_CYC,    // Page program duration.
	parameter int unsigned ERASE_CYC = fps_pkg::ERASE_TYP_CYC, // Page/sector/block erase.
	parameter int unsigned CHIP_CYC  = fps_pkg::CHIP_TYP_CYC   // Chip erase duration.
) (
	input  wire logic        pclk,    // APB clock, 100 MHz.
	input  wire logic        presetn, // Asynchronous reset, active low.
	input  wire logic        psel,    // APB select.
	input  wire logic        penable, // APB enable.
	input  wire logic        pwrite,  // APB direction, high for write.
	input  wire logic [7:0]  paddr,   // APB byte address.
	input  wire logic [31:0] pwdata,  // APB write data.
	output logic      [31:0] prdata,  // APB read data.
	output logic             pready,  // APB ready.
	output logic             pslverr, // APB error on unmapped address.
	input  wire logic        wp_n,    // Write protect pin, active low.
	output logic             irq      // Level interrupt.
);
	import fps_pkg::*;

	typedef struct packed {
		fps_state_t  st;
		logic        write_enable_latch;
		logic [4:0]  bp;
		logic [1:0]  srp;
		logic [7:0]  op;
		logic [23:0] addr;
		logic [10:0] wdata;
		logic [2:0]  irq_st;
		logic [2:0]  irq_msk;
		logic [31:0] prdata;
		logic        wp_s1;
		logic        wp_s2;
	} fps_seq_state_t;

	fps_seq_state_t r_ff;
	fps_seq_state_t nxt_r;

	fps_tmr_if op_tif ();
	fps_tmr_if lat_tif ();

	fps_timer u_op_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (op_tif.tmr)
	);

	fps_timer u_lat_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (lat_tif.tmr)
	);

	// ****************************************************************
	// Protection decode
	// ****************************************************************
	function automatic logic prot_hit(input logic [4:0] bp, input logic [23:0] lo,
		input logic [23:0] hi);
		logic [23:0] size;
		logic [23:0] plo;
		logic [23:0] phi;
		logic [2:0]  n;
		n = bp[2:0];
		if (n == 3'h0) begin
			return 1'b0;
		end
		if (n == 3'h7) begin
			return 1'b1;
		end
		if (!bp[4]) begin
			size = BP_BIG_UNIT << (n - 3'h1);
		end else begin
			size = BP_SMALL_UNIT << (((n > 3'h4) ? 3'h4 : n) - 3'h1);
		end
		if (bp[3]) begin
			plo = 24'h000000;
			phi = size - 24'h000001;
		end else begin
			plo = 24'h000000 - size;
			phi = 24'hFFFFFF;
		end
		return !(hi < plo || lo > phi);
	endfunction : prot_hit

	function automatic logic [23:0] span_mask(input logic [7:0] op);
		case (op)
			CMD_PP, CMD_PE: return 24'h0000FF;
			CMD_SE:         return 24'h000FFF;
			CMD_BE32:       return 24'h007FFF;
			CMD_BE64:       return 24'h00FFFF;
			default:        return 24'hFFFFFF;
		endcase
	endfunction : span_mask

	// ****************************************************************
	// Sequencer and register file
	// ****************************************************************
	logic        apb_wr;
	logic        cmd_fire;
	logic [7:0]  cmd_op;
	logic [5:0]  cmd_bits;
	logic [23:0] rng_lo;
	logic [23:0] rng_hi;
	logic        is_change;
	logic        ev_done;
	logic        ev_rej;
	logic        ev_susp;
	logic        op_start;
	logic [31:0] op_len;
	logic [2:0]  w1c;
	logic [31:0] status;
	logic        mapped;

	always_comb begin
		nxt_r     = r_ff;
		nxt_r.wp_s1 = wp_n;
		nxt_r.wp_s2 = r_ff.wp_s1;
		apb_wr    = psel && penable && pwrite;
		cmd_op    = pwdata[7:0];
		cmd_bits  = pwdata[13:8];
		cmd_fire  = apb_wr && (paddr == OFF_CMD);
		rng_lo    = r_ff.addr & ~span_mask(cmd_op);
		rng_hi    = rng_lo | span_mask(cmd_op);
		is_change = (cmd_op == CMD_PP) || (cmd_op == CMD_PE) || (cmd_op == CMD_SE) ||
			(cmd_op == CMD_BE32) || (cmd_op == CMD_BE64) || (cmd_op == CMD_CE);
		ev_done   = 1'b0;
		ev_rej    = 1'b0;
		ev_susp   = 1'b0;
		op_start  = 1'b0;
		w1c       = 3'h0;
		case (cmd_op)
			CMD_PP:  op_len = 32'(PP_CYC);
			CMD_CE:  op_len = 32'(CHIP_CYC);
			default: op_len = 32'(ERASE_CYC);
		endcase
		if (apb_wr) begin
			case (paddr)
				OFF_ADDR:    nxt_r.addr = pwdata[23:0];
				OFF_WDATA:   nxt_r.wdata = pwdata[10:0];
				OFF_IRQ_ST:  w1c = pwdata[2:0];
				OFF_IRQ_MSK: nxt_r.irq_msk = pwdata[2:0];
				default:     nxt_r.addr = r_ff.addr;
			endcase
		end
		// Completion clears the latch so a new change needs a fresh enable.
		if (r_ff.st == st_busy && op_tif.done) begin
			nxt_r.st  = st_idle;
			nxt_r.write_enable_latch = 1'b0;
			ev_done   = 1'b1;
		end
		if (r_ff.st == st_suspending && lat_tif.done) begin
			nxt_r.st = st_suspended;
			ev_susp  = 1'b1;
		end
		if (cmd_fire) begin
			if (cmd_bits[2:0] != 3'h0 || cmd_bits == 6'h00) begin
				ev_rej = 1'b1;
			end else if (r_ff.st == st_dpd) begin
				if (cmd_op == CMD_RDP) begin
					nxt_r.st = st_idle;
				end else begin
					ev_rej = 1'b1;
				end
			end else begin
				case (r_ff.st)
					st_idle: begin
						if (cmd_op == CMD_WRITE_ENABLE_COMMAND) begin
							nxt_r.write_enable_latch = 1'b1;
						end else if (cmd_op == CMD_WRDI) begin
							nxt_r.write_enable_latch = 1'b0;
						end else if (cmd_op == CMD_DP) begin
							nxt_r.st = st_dpd;
						end else if (cmd_op == CMD_WRSR) begin
							if (!r_ff.write_enable_latch || !r_ff.wp_s2) begin
								ev_rej = 1'b1;
							end else begin
								nxt_r.bp  = r_ff.wdata[ST_SRP_LSB-1:ST_BP_LSB];
								nxt_r.srp = r_ff.wdata[ST_SUSP-1:ST_SRP_LSB];
								nxt_r.write_enable_latch = 1'b0;
							end
						end else if (is_change) begin
							if (!r_ff.write_enable_latch || prot_hit(r_ff.bp, rng_lo, rng_hi)) begin
								ev_rej = 1'b1;
							end else begin
								nxt_r.st = st_busy;
								nxt_r.op = cmd_op;
								op_start = 1'b1;
							end
						end
					end
					st_busy: begin
						if (cmd_op == CMD_SUSP && !op_tif.done) begin
							nxt_r.st = st_suspending;
						end else begin
							ev_rej = 1'b1;
						end
					end
					st_suspended: begin
						if (cmd_op == CMD_RESUME) begin
							nxt_r.st = st_busy;
						end else begin
							ev_rej = 1'b1;
						end
					end
					default: ev_rej = 1'b1;
				endcase
			end
		end
		// A new event wins over a clear written in the same cycle.
		nxt_r.irq_st = (r_ff.irq_st & ~w1c) | {ev_susp, ev_rej, ev_done};
		status = 32'h00000000;
		status[ST_BUSY] = (r_ff.st != st_idle) && (r_ff.st != st_dpd);
		status[ST_WEL] = r_ff.write_enable_latch;
		status[ST_SRP_LSB-1:ST_BP_LSB] = r_ff.bp;
		status[ST_SUSP-1:ST_SRP_LSB] = r_ff.srp;
		status[ST_SUSP] = (r_ff.st == st_suspended);
		status[ST_DPD] = (r_ff.st == st_dpd);
		mapped = 1'b1;
		case (paddr)
			OFF_CMD:     nxt_r.prdata = {24'h000000, r_ff.op};
			OFF_ADDR:    nxt_r.prdata = {8'h00, r_ff.addr};
			OFF_WDATA:   nxt_r.prdata = {21'h000000, r_ff.wdata};
			OFF_STATUS:  nxt_r.prdata = status;
			OFF_IRQ_ST:  nxt_r.prdata = {29'h00000000, r_ff.irq_st};
			OFF_IRQ_MSK: nxt_r.prdata = {29'h00000000, r_ff.irq_msk};
			OFF_ARRAY:   nxt_r.prdata = {24'h000000, ERASED_BYTE};
			default: begin
				nxt_r.prdata = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
		if (!(psel && !penable)) begin
			nxt_r.prdata = r_ff.prdata;
		end
	end

	assign op_tif.load   = op_start;
	assign op_tif.value  = op_len;
	assign op_tif.run    = (r_ff.st == st_busy);
	assign lat_tif.load  = cmd_fire && (r_ff.st == st_busy) && (nxt_r.st == st_suspending);
	assign lat_tif.value = 32'(SUSP_LAT_CYC);
	assign lat_tif.run   = (r_ff.st == st_suspending);

	assign prdata  = r_ff.prdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq     = |(r_ff.irq_st & r_ff.irq_msk);

	// Reset is the power-up path: idle, status and mask all zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '{st: st_idle, bp: BP_RST, srp: SRP_RST, wp_s1: 1'b1, wp_s2: 1'b1,
				default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	int unsigned lat_cnt_ff;
	int unsigned run_cnt_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_cnt_ff <= 0;
			run_cnt_ff <= 0;
		end else begin
			lat_cnt_ff <= (r_ff.st == st_suspending) ? lat_cnt_ff + 1 : 0;
			run_cnt_ff <= op_start ? 0 : ((r_ff.st == st_busy) ? run_cnt_ff + 1 : run_cnt_ff);
		end
	end

	property p_susp_lat;
		@(posedge pclk) disable iff (!presetn) lat_cnt_ff <= SUSP_LAT_CYC;
	endproperty
	a_susp_lat: assert property (p_susp_lat) else $error("suspend latency too long");

	property p_pp_time;
		@(posedge pclk) disable iff (!presetn)
			(ev_done && r_ff.op == CMD_PP) |-> (run_cnt_ff + 1 == PP_CYC && PP_CYC <= PP_MAX_CYC);
	endproperty
	a_pp_time: assert property (p_pp_time) else $error("page program time wrong");

	property p_erase_time;
		@(posedge pclk) disable iff (!presetn)
			(ev_done && r_ff.op != CMD_PP) |->
			(r_ff.op == CMD_CE ? run_cnt_ff + 1 <= CHIP_MAX_CYC : run_cnt_ff + 1 <= ERASE_MAX_CYC);
	endproperty
	a_erase_time: assert property (p_erase_time) else $error("erase time too long");

	property p_busy_cause;
		@(posedge pclk) disable iff (!presetn)
			$rose(status[ST_BUSY]) |-> $past(cmd_fire) && $past(r_ff.write_enable_latch);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without enabled command");

	property p_len_check;
		@(posedge pclk) disable iff (!presetn)
			(cmd_fire && cmd_bits[2:0] != 3'h0) |=> $stable(r_ff.st) && $stable(r_ff.bp) &&
			r_ff.irq_st[IRQ_REJ];
	endproperty
	a_len_check: assert property (p_len_check) else $error("partial byte command acted on");

	property p_wp_lock;
		@(posedge pclk) disable iff (!presetn) !r_ff.wp_s2 |=> $stable(r_ff.bp) && $stable(r_ff.srp);
	endproperty
	a_wp_lock: assert property (p_wp_lock) else $error("protect bits changed under write protect");

	property p_dpd_filter;
		@(posedge pclk) disable iff (!presetn)
			(r_ff.st == st_dpd && cmd_fire && cmd_op != CMD_RDP) |=> r_ff.st == st_dpd;
	endproperty
	a_dpd_filter: assert property (p_dpd_filter) else $error("command run in deep power-down");

	property p_prot;
		@(posedge pclk) disable iff (!presetn)
			(cmd_fire && is_change && r_ff.st == st_idle && prot_hit(r_ff.bp, rng_lo, rng_hi))
			|=> r_ff.st == st_idle ##1 r_ff.st == st_idle;
	endproperty
	a_prot: assert property (p_prot) else $error("protected region changed");

	property p_done_wel;
		@(posedge pclk) disable iff (!presetn) ev_done |=> !r_ff.write_enable_latch && !status[ST_BUSY];
	endproperty
	a_done_wel: assert property (p_done_wel) else $error("latch not cleared at completion");

	c_program: cover property (@(posedge pclk) disable iff (!presetn) ev_done && r_ff.op == CMD_PP);
	c_suspend: cover property (@(posedge pclk) disable iff (!presetn) ev_susp);
	c_dpd: cover property (@(posedge pclk) disable iff (!presetn) $rose(status[ST_DPD]));

endmodule : fps_flash_seq

//--- tb/fps_host_model.sv
module fps_host_model (
	input  wire logic        pclk,    // Bus clock.
	output logic             psel,    // Bus select.
	output logic             penable, // Bus enable.
	output logic             pwrite,  // Bus direction, high for write.
	output logic [7:0]       paddr,   // Byte address.
	output logic [31:0]      pwdata,  // Write data.
	input  wire logic [31:0] prdata,  // Read data.
	input  wire logic        pready,  // Slave ready.
	input  wire logic        pslverr, // Slave error.
	output logic             stuck    // High once a transfer never completed.
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Bus master
	// ****************************************************************
	// Select stays low from time zero until the bench asks for a transfer after reset.
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		stuck   = 1'b0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) begin
			stuck <= 1'b1;
		end
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// The sequencer does not police resume-to-suspend spacing, so the host must.
	task automatic hold_off(input int cyc);
		repeat (cyc) @(posedge pclk);
	endtask : hold_off

endmodule : fps_host_model

//--- tb/flash_program_erase_protection_bench.sv
module flash_program_erase_protection_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import fps_pkg::*;

	localparam int PP_N = 20;
	localparam int ER_N = 30;
	localparam int CE_N = 40;

	logic        pclk;
	logic        presetn;
	logic        wp_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        stuck;
	int          errors;
	int          check_count;

	fps_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stuck(stuck));

	fps_flash_seq #(.PP_CYC(PP_N), .ERASE_CYC(ER_N), .CHIP_CYC(CE_N)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wp_n(wp_n), .irq(irq));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b0, a, 32'h00000000, q, e);
		chk(what, exp, q);
	endtask : rdchk

	task automatic cmd(input logic [7:0] op, input logic [5:0] bits);
		wr(OFF_CMD, {18'h00000, bits, op});
	endtask : cmd

	// Polling costs three cycles a read and starts after the busy read, so the measured
	// duration can fall up to one poll short of the operation length.
	task automatic wait_st(input int idx, input logic val, output int dt);
		time         t0;
		logic [31:0] q;
		logic        e;
		int          n;
		t0 = $time;
		n = 0;
		do begin
			host.xfer(1'b0, OFF_STATUS, 32'h00000000, q, e);
			n++;
		end while (q[idx] !== val && n < 2000);
		if (q[idx] !== val) begin
			errors++;
			$display("mismatch status bit %0d expected %b seen %b", idx, val, q[idx]);
			test_done();
		end
		dt = int'(($time - t0) / 10);
	endtask : wait_st

	task automatic run_op(input string what, input logic [7:0] op, input logic [5:0] bits,
			input int n);
		int dt;
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		cmd(op, bits);
		rdchk({what, " busy"}, OFF_STATUS, 32'h00000003);
		wait_st(ST_BUSY, 1'b0, dt);
		chk({what, " time"}, 32'h1, {31'h0, dt + 3 >= n && dt <= n + 6});
		rdchk({what, " after"}, OFF_STATUS, 32'h00000000);
	endtask : run_op

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rdchk("status", OFF_STATUS, 32'h00000000);
		rdchk("array", OFF_ARRAY, 32'h000000FF);
		rdchk("irq status", OFF_IRQ_ST, 32'h00000000);
		host.xfer(1'b0, 8'h1C, 32'h00000000, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask : t_reset

	task automatic t_wel();
		wr(OFF_ADDR, 32'h00000000);
		cmd(CMD_PP, 6'h20);
		rdchk("no latch", OFF_IRQ_ST, 32'h00000002);
		rdchk("no latch st", OFF_STATUS, 32'h00000000);
		wr(OFF_IRQ_ST, 32'h00000007);
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		rdchk("latch", OFF_STATUS, 32'h00000002);
		cmd(CMD_PP, 6'h0C);
		rdchk("short cmd", OFF_IRQ_ST, 32'h00000002);
		rdchk("short st", OFF_STATUS, 32'h00000002);
		cmd(CMD_WRDI, 6'h08);
		wr(OFF_IRQ_ST, 32'h00000007);
		run_op("program", CMD_PP, 6'h20, PP_N);
		rdchk("done", OFF_IRQ_ST, 32'h00000001);
		wr(OFF_IRQ_ST, 32'h00000007);
		$display("test latch done");
	endtask : t_wel

	task automatic t_erase();
		run_op("page erase", CMD_PE, 6'h20, ER_N);
		run_op("sector erase", CMD_SE, 6'h20, ER_N);
		run_op("block32 erase", CMD_BE32, 6'h20, ER_N);
		run_op("block64 erase", CMD_BE64, 6'h20, ER_N);
		run_op("chip erase", CMD_CE, 6'h08, CE_N);
		wr(OFF_IRQ_ST, 32'h00000007);
		$display("test erase done");
	endtask : t_erase

	task automatic t_protect();
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		wr(OFF_WDATA, 32'h00000044);
		cmd(CMD_WRSR, 6'h10);
		rdchk("protect set", OFF_STATUS, 32'h00000044);
		wr(OFF_ADDR, 32'h00FF0000);
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		cmd(CMD_BE64, 6'h20);
		rdchk("overlap st", OFF_STATUS, 32'h00000046);
		rdchk("overlap irq", OFF_IRQ_ST, 32'h00000002);
		wr(OFF_ADDR, 32'h00FFF800);
		cmd(CMD_PP, 6'h20);
		rdchk("inside st", OFF_STATUS, 32'h00000046);
		wr(OFF_ADDR, 32'h00FE0000);
		cmd(CMD_BE64, 6'h20);
		rdchk("outside st", OFF_STATUS, 32'h00000047);
		rdchk("array read", OFF_ARRAY, 32'h000000FF);
		wr(OFF_IRQ_ST, 32'h00000007);
		$display("test protect done");
	endtask : t_protect

	task automatic t_wp();
		int dt;
		wait_st(ST_BUSY, 1'b0, dt);
		wp_n <= 1'b0;
		repeat (4) @(posedge pclk);
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		wr(OFF_WDATA, 32'h00000000);
		cmd(CMD_WRSR, 6'h10);
		rdchk("pin locked", OFF_STATUS, 32'h00000046);
		rdchk("pin irq", OFF_IRQ_ST, 32'h00000003);
		wp_n <= 1'b1;
		repeat (4) @(posedge pclk);
		cmd(CMD_WRSR, 6'h10);
		rdchk("pin free", OFF_STATUS, 32'h00000000);
		wr(OFF_IRQ_ST, 32'h00000007);
		$display("test pin done");
	endtask : t_wp

	task automatic t_susp();
		int dt;
		wr(OFF_IRQ_MSK, 32'h00000004);
		rdchk("mask", OFF_IRQ_MSK, 32'h00000004);
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		cmd(CMD_CE, 6'h08);
		cmd(CMD_SUSP, 6'h08);
		chk("irq early", 32'h0, {31'h0, irq});
		wait_st(ST_SUSP, 1'b1, dt);
		chk("suspend time", 32'h1, {31'h0, dt <= SUSP_LAT_CYC + 6});
		chk("irq raised", 32'h1, {31'h0, irq});
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		rdchk("suspended irq", OFF_IRQ_ST, 32'h00000006);
		wr(OFF_IRQ_ST, 32'h00000004);
		// The clear lands on the edge the write returns at, so look once it has settled.
		@(negedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		cmd(CMD_RESUME, 6'h08);
		host.hold_off(2000);
		rdchk("resumed", OFF_STATUS, 32'h00000000);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFF_IRQ_MSK, 32'h00000000);
		wr(OFF_IRQ_ST, 32'h00000007);
		$display("test suspend done");
	endtask : t_susp

	task automatic t_dpd();
		cmd(CMD_DP, 6'h08);
		rdchk("deep", OFF_STATUS, 32'h00000400);
		cmd(CMD_WRITE_ENABLE_COMMAND, 6'h08);
		rdchk("deep ignore", OFF_STATUS, 32'h00000400);
		cmd(CMD_RDP, 6'h08);
		rdchk("wake", OFF_STATUS, 32'h00000000);
		$display("test deep done");
	endtask : t_dpd

	// ****************************************************************
	// Run
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		test_done();
	end

	always @(posedge stuck) begin
		errors++;
		test_done();
	end

	initial begin
		errors = 0;
		check_count = 0;
		presetn = 1'b0;
		wp_n = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_wel();
		t_erase();
		t_protect();
		t_wp();
		t_susp();
		t_dpd();
		test_done();
	end

endmodule : flash_program_erase_protection_bench
